//--- rtl/nmcp_pkg.sv
/*
  Shared constants and types of the Normal Mode command parser: command
  characters, command words, datagram kinds, operating modes, request, status and byte structures.
  Assumes one 40 MHz core clock and an 8-bit byte stream from a receiver.
*/
// Functional notes
// - Only upper-case command forms are recognised
// - Carriage return executes the collected characters
// - No echo and no error reply
// - Only complete correct commands cause action
// - Eight commands: six letters, two words
// - Special datagram takes next measurement slot
// - Long special datagram suppresses following slots
// - External trigger mode: special on next trigger
// - Error registers cleared after error datagram sent
// - Reset letter pulses full unit reset
// - Service word enters Service Mode
// - Service switch waits for datagram end
// - Service entry starts configuration listing
// - Increments during special datagram are discarded
// - Utility switch waits for datagram end
// - Utility entry stops datagrams, sends acknowledgement
package nmcp_pkg;

  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;

  // Command characters
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_PART = 8'h4e;
  localparam logic [7:0] CHAR_SERIAL = 8'h49;
  localparam logic [7:0] CHAR_CONFIG = 8'h43;
  localparam logic [7:0] CHAR_TRIM = 8'h54;
  localparam logic [7:0] CHAR_ERROR = 8'h45;
  localparam logic [7:0] CHAR_RESET = 8'h52;

  // Command words, first character in the top byte
  localparam int WORD_CHARS = 11;
  localparam logic [4*BYTE_W-1:0] LEN_UNUSED = 32'h0;
  localparam logic [3:0] WORD_LEN = 4'hb;
  localparam logic [3:0] LEN_MAX = 4'hc;
  localparam logic [WORD_CHARS*BYTE_W-1:0] SERVICE_WORD = 88'h534552564943454d4f4445;
  localparam logic [WORD_CHARS*BYTE_W-1:0] UTILITY_WORD = 88'h5554494c4954594d4f4445;

  typedef enum logic [1:0] {
    NMCP_MODE_NORMAL,
    NMCP_MODE_SERVICE,
    NMCP_MODE_UTILITY
  } nmcp_mode_e;

  typedef enum logic [2:0] {
    NMCP_DG_MEASURE,
    NMCP_DG_PART,
    NMCP_DG_SERIAL,
    NMCP_DG_CONFIG,
    NMCP_DG_TRIM,
    NMCP_DG_ERROR
  } nmcp_dg_kind_e;

  // Datagram start request towards the transmitter
  typedef struct packed {
    logic start;
    nmcp_dg_kind_e kind;
  } nmcp_dg_req_s;

  // Status from the datagram transmitter
  typedef struct packed {
    logic busy;
    logic done;
  } nmcp_tx_stat_s;

  // Byte stream carrier
  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } nmcp_byte_s;

endpackage

//--- rtl/nmcp_fifo.sv
/*
  Byte FIFO with valid/ready on both sides and a register array.
  Assumes both sides run on the core clock.
*/
`timescale 1ns/1ps
module nmcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } nmcp_fifo_s;

  nmcp_fifo_s st_reg;
  nmcp_fifo_s st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data = mem[st_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[st_reg.wr_ptr] <= in_data;
    end
  end

endmodule

//--- rtl/nmcp_parser.sv
/*
  Normal Mode command parser and special datagram scheduler.
  Assumes a byte receiver on the core clock, a datagram transmitter that
  raises busy the cycle after a start and pulses done at the end, and a
  sampler that pulses one measurement slot per sample period.
*/
`timescale 1ns/1ps
module nmcp_parser (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Received bytes
  input wire nmcp_pkg::nmcp_byte_s rx_byte,
  output logic rx_ready,
  // Bytes handed on outside Normal Mode
  output nmcp_pkg::nmcp_byte_s aux_byte,
  input wire logic aux_ready,
  // Sampling
  input wire logic meas_slot,
  input wire logic ext_trig_mode,
  input wire logic ext_trig_pin,
  input wire logic incremental_mode,
  // Transmitter
  output nmcp_pkg::nmcp_dg_req_s dg_req,
  input wire nmcp_pkg::nmcp_tx_stat_s tx_stat,
  // System actions
  output logic err_clear,
  output logic unit_reset,
  output logic listing_start,
  output logic utility_ack_start,
  output logic incr_discard,
  input wire logic mode_exit,
  output nmcp_pkg::nmcp_mode_e mode
);
  import nmcp_pkg::*;

  typedef struct packed {
    nmcp_mode_e mode;
    logic [3:0] len;
    logic [7:0] first;
    logic svc_ok;
    logic util_ok;
    logic pend_valid;
    nmcp_dg_kind_e pend_kind;
    logic sw_valid;
    nmcp_mode_e sw_target;
    logic spec_active;
    nmcp_dg_kind_e act_kind;
    logic trig_s1;
    logic trig_s2;
    logic trig_d;
    nmcp_dg_req_s req;
    logic err_clear;
    logic unit_reset;
    logic listing_start;
    logic ack_start;
  } nmcp_state_s;

  nmcp_state_s st_reg;
  nmcp_state_s st_next;

  logic fifo_valid;
  logic [BYTE_W-1:0] fifo_data;
  logic fifo_ready;
  logic take;
  logic is_cr;
  logic slot;
  logic can_start;
  logic letter_hit;
  nmcp_dg_kind_e letter_kind;
  logic [6:0] char_pos;

  nmcp_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(rx_byte.valid),
    .in_data(rx_byte.data),
    .in_ready(rx_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_ready)
  );

  // Parser stalls while a mode switch waits; other modes hand bytes on
  assign fifo_ready = (st_reg.mode == NMCP_MODE_NORMAL) ? !st_reg.sw_valid : aux_ready;
  assign take = fifo_valid && fifo_ready && (st_reg.mode == NMCP_MODE_NORMAL);
  assign is_cr = (fifo_data == CHAR_CR);
  assign aux_byte.valid = fifo_valid && (st_reg.mode != NMCP_MODE_NORMAL);
  assign aux_byte.data = fifo_data;
  assign char_pos = 7'(8 * (WORD_CHARS - 1 - int'(st_reg.len)));

  // Single-letter decode, upper case only
  always_comb begin
    letter_hit = 1'b1;
    letter_kind = NMCP_DG_MEASURE;
    unique case (st_reg.first)
      CHAR_PART: letter_kind = NMCP_DG_PART;
      CHAR_SERIAL: letter_kind = NMCP_DG_SERIAL;
      CHAR_CONFIG: letter_kind = NMCP_DG_CONFIG;
      CHAR_TRIM: letter_kind = NMCP_DG_TRIM;
      CHAR_ERROR: letter_kind = NMCP_DG_ERROR;
      default: letter_hit = 1'b0;
    endcase
  end

  // Slot is the sampler pulse or a synchronised trigger edge
  assign slot = ext_trig_mode ? (st_reg.trig_s2 && !st_reg.trig_d) : meas_slot;
  // A busy transmitter swallows the slot
  assign can_start = slot && !tx_stat.busy && !st_reg.req.start
                     && (st_reg.mode == NMCP_MODE_NORMAL) && !st_reg.sw_valid;

  always_comb begin
    st_next = st_reg;
    st_next.trig_s1 = ext_trig_pin;
    st_next.trig_s2 = st_reg.trig_s1;
    st_next.trig_d = st_reg.trig_s2;
    st_next.req = '0;
    st_next.err_clear = 1'b0;
    st_next.unit_reset = 1'b0;
    st_next.listing_start = 1'b0;
    st_next.ack_start = 1'b0;

    // Datagram end
    if (tx_stat.done && st_reg.spec_active) begin
      st_next.spec_active = 1'b0;
      if (st_reg.act_kind == NMCP_DG_ERROR) begin
        st_next.err_clear = 1'b1;
      end
    end

    // Slot use: pending special replaces the measurement datagram
    if (can_start) begin
      st_next.req.start = 1'b1;
      if (st_reg.pend_valid) begin
        st_next.req.kind = st_reg.pend_kind;
        st_next.pend_valid = 1'b0;
        st_next.spec_active = 1'b1;
        st_next.act_kind = st_reg.pend_kind;
      end else begin
        st_next.req.kind = NMCP_DG_MEASURE;
      end
    end

    // Character collection; nothing is ever sent back
    if (take) begin
      if (is_cr) begin
        if (st_reg.len == 4'h1 && letter_hit) begin
          st_next.pend_valid = 1'b1;
          st_next.pend_kind = letter_kind;
        end
        if (st_reg.len == 4'h1 && st_reg.first == CHAR_RESET) begin
          st_next.unit_reset = 1'b1;
        end
        if (st_reg.len == WORD_LEN && st_reg.svc_ok) begin
          st_next.sw_valid = 1'b1;
          st_next.sw_target = NMCP_MODE_SERVICE;
        end
        if (st_reg.len == WORD_LEN && st_reg.util_ok) begin
          st_next.sw_valid = 1'b1;
          st_next.sw_target = NMCP_MODE_UTILITY;
        end
        st_next.len = '0;
        st_next.first = '0;
        st_next.svc_ok = 1'b1;
        st_next.util_ok = 1'b1;
      end else begin
        if (st_reg.len == '0) begin
          st_next.first = fifo_data;
        end
        if (st_reg.len < WORD_LEN) begin
          st_next.svc_ok = st_reg.svc_ok && (fifo_data == SERVICE_WORD[char_pos +: 8]);
          st_next.util_ok = st_reg.util_ok && (fifo_data == UTILITY_WORD[char_pos +: 8]);
        end else begin
          st_next.svc_ok = 1'b0;
          st_next.util_ok = 1'b0;
        end
        if (st_reg.len != LEN_MAX) begin
          st_next.len = st_reg.len + 4'h1;
        end
      end
    end

    // Mode switch once the transmitter is idle
    if (st_reg.sw_valid && !tx_stat.busy && !st_reg.req.start) begin
      st_next.sw_valid = 1'b0;
      st_next.mode = st_reg.sw_target;
      st_next.pend_valid = 1'b0;
      st_next.spec_active = 1'b0;
      if (st_reg.sw_target == NMCP_MODE_SERVICE) begin
        st_next.listing_start = 1'b1;
      end else begin
        st_next.ack_start = 1'b1;
      end
    end

    if (mode_exit && st_reg.mode != NMCP_MODE_NORMAL) begin
      st_next.mode = NMCP_MODE_NORMAL;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{mode: NMCP_MODE_NORMAL, svc_ok: 1'b1, util_ok: 1'b1,
                  pend_kind: NMCP_DG_MEASURE, sw_target: NMCP_MODE_NORMAL,
                  act_kind: NMCP_DG_MEASURE, req: '0, first: 8'h00, len: 4'h0,
                  default: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign dg_req = st_reg.req;
  assign err_clear = st_reg.err_clear;
  assign unit_reset = st_reg.unit_reset;
  assign listing_start = st_reg.listing_start;
  assign utility_ack_start = st_reg.ack_start;
  assign incr_discard = st_reg.spec_active && incremental_mode;
  assign mode = st_reg.mode;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_CR_CLEARS: assert property (take && is_cr |=> st_reg.len == 4'h0)
    else $error("collected characters survive a carriage return");
  AST_LOWER_IGNORED: assert property (take && is_cr && st_reg.len == 4'h1
      && st_reg.first == 8'h6e |=> !st_reg.pend_valid || $past(st_reg.pend_valid))
    else $error("lower-case letter accepted");
  AST_NO_CR_NO_ACTION: assert property (!(take && is_cr) |=> !unit_reset
      && !($rose(st_reg.sw_valid)))
    else $error("action without carriage return");
  AST_SPECIAL_IN_SLOT: assert property (can_start && st_reg.pend_valid
      |=> dg_req.start && dg_req.kind == $past(st_reg.pend_kind))
    else $error("pending special not sent in slot");
  AST_BUSY_SUPPRESS: assert property (tx_stat.busy |=> !dg_req.start)
    else $error("datagram started while transmitter busy");
  AST_ERR_CLEAR: assert property (tx_stat.done && st_reg.spec_active
      && st_reg.act_kind == NMCP_DG_ERROR |=> err_clear)
    else $error("error registers not cleared after error datagram");
  AST_RESET_CMD: assert property (take && is_cr && st_reg.len == 4'h1
      && st_reg.first == CHAR_RESET |=> unit_reset ##1 !unit_reset)
    else $error("reset command did not pulse once");
  AST_SWITCH_WAITS: assert property ($changed(mode) && mode != NMCP_MODE_NORMAL
      |-> $past(!tx_stat.busy))
    else $error("mode switched during a datagram");
  AST_LISTING: assert property ($rose(mode == NMCP_MODE_SERVICE) |-> listing_start)
    else $error("no listing on entering service mode");
  AST_UTIL_QUIET: assert property (mode == NMCP_MODE_UTILITY |=> !dg_req.start
      || $past(mode_exit))
    else $error("datagram started in utility mode");
  AST_DISCARD: assert property (dg_req.start && dg_req.kind != NMCP_DG_MEASURE
      && incremental_mode |-> incr_discard)
    else $error("increments not discarded during special datagram");

  // Byte path
  AST_NO_ECHO: assert property (mode == NMCP_MODE_NORMAL |-> !aux_byte.valid)
    else $error("byte handed on in normal mode");
  AST_AUX_NO_PARSE: assert property (mode != NMCP_MODE_NORMAL |-> !take)
    else $error("byte parsed outside normal mode");
  AST_STALL_SWITCH: assert property (st_reg.sw_valid |-> !take)
    else $error("byte parsed while a switch waits");
  AST_LEN_GROWS: assert property (take && !is_cr && st_reg.len != LEN_MAX
      |=> st_reg.len == $past(st_reg.len) + 4'h1)
    else $error("character count did not advance");
  AST_LEN_LIMIT: assert property (st_reg.len <= LEN_MAX)
    else $error("character count beyond its limit");
  AST_FIRST_KEPT: assert property (take && !is_cr && st_reg.len == 4'h0
      |=> st_reg.first == $past(fifo_data))
    else $error("first character not kept");
  AST_WORD_MISS: assert property (take && !is_cr && st_reg.len >= WORD_LEN
      |=> !st_reg.svc_ok && !st_reg.util_ok)
    else $error("overlong word still matches");
  AST_CR_RESTARTS: assert property (take && is_cr
      |=> st_reg.svc_ok && st_reg.util_ok && st_reg.first == 8'h00)
    else $error("word match not restarted after carriage return");

  // Command decisions
  AST_LETTER_PENDS: assert property (take && is_cr && st_reg.len == 4'h1 && letter_hit
      |=> st_reg.pend_valid && st_reg.pend_kind == $past(letter_kind))
    else $error("letter request not made pending");
  AST_CR_NO_LETTER: assert property (take && is_cr && st_reg.len == 4'h1 && !letter_hit
      && !st_reg.pend_valid |=> !st_reg.pend_valid)
    else $error("unknown letter made a request pending");
  AST_LONG_NO_PEND: assert property (take && is_cr && st_reg.len != 4'h1
      && !st_reg.pend_valid |=> !st_reg.pend_valid)
    else $error("request pending after a malformed command");
  AST_RESET_ONLY_R: assert property (unit_reset |-> $past(take) && $past(is_cr)
      && $past(st_reg.first) == CHAR_RESET)
    else $error("unit reset without its command");
  AST_SWITCH_WORD: assert property ($rose(st_reg.sw_valid) |-> $past(take) && $past(is_cr)
      && $past(st_reg.len) == WORD_LEN)
    else $error("switch pending without a full word");
  AST_SVC_TARGET: assert property ($rose(st_reg.sw_valid) && $past(st_reg.svc_ok)
      |-> st_reg.sw_target == NMCP_MODE_SERVICE)
    else $error("service word aims elsewhere");
  AST_UTIL_TARGET: assert property ($rose(st_reg.sw_valid) && $past(st_reg.util_ok)
      |-> st_reg.sw_target == NMCP_MODE_UTILITY)
    else $error("utility word aims elsewhere");

  // Slots and datagrams
  AST_START_ONE: assert property (dg_req.start |=> !dg_req.start)
    else $error("start held longer than a cycle");
  AST_START_FROM_SLOT: assert property (dg_req.start |-> $past(slot))
    else $error("datagram started without a slot");
  AST_MEASURE_PLAIN: assert property (can_start && !st_reg.pend_valid
      |=> dg_req.start && dg_req.kind == NMCP_DG_MEASURE)
    else $error("slot without request did not start a measurement");
  AST_TRIG_SLOT: assert property ($past(ext_trig_mode) && dg_req.start
      |-> $past(st_reg.trig_s2) && !$past(st_reg.trig_d))
    else $error("triggered datagram without a trigger edge");
  AST_PEND_KEEPS: assert property (st_reg.pend_valid && !can_start && !st_reg.sw_valid
      |=> st_reg.pend_valid)
    else $error("pending request lost");
  AST_SPEC_HELD: assert property (st_reg.spec_active && !tx_stat.done
      |=> st_reg.spec_active)
    else $error("special datagram dropped before its end");
  AST_NO_SLOT_SWITCH: assert property (st_reg.sw_valid || mode != NMCP_MODE_NORMAL
      |=> !dg_req.start)
    else $error("datagram started around a mode switch");

  // Mode changes and side effects
  AST_ERR_ONLY_ERROR: assert property (err_clear |-> $past(tx_stat.done)
      && $past(st_reg.act_kind) == NMCP_DG_ERROR)
    else $error("error clear after another datagram");
  AST_ERR_CLEAR_ONE: assert property (err_clear |=> !err_clear)
    else $error("error clear held longer than a cycle");
  AST_LISTING_SVC: assert property (listing_start |-> mode == NMCP_MODE_SERVICE)
    else $error("listing outside service mode");
  AST_ACK_UTIL: assert property (utility_ack_start |-> mode == NMCP_MODE_UTILITY)
    else $error("acknowledgement outside utility mode");
  AST_SWITCH_DROPS: assert property ($rose(mode != NMCP_MODE_NORMAL)
      |-> !st_reg.pend_valid && !st_reg.spec_active)
    else $error("request survives a mode switch");
  AST_DISCARD_END: assert property (tx_stat.done && st_reg.spec_active
      |=> !incr_discard)
    else $error("increments still discarded after special datagram");

  COV_SPECIAL: cover property (dg_req.start && dg_req.kind != NMCP_DG_MEASURE);
  COV_SERVICE: cover property (listing_start);
  COV_UTILITY: cover property (utility_ack_start);
  COV_FIFO_FULL: cover property (!rx_ready);
  COV_TRIGGER: cover property (ext_trig_mode && slot && st_reg.pend_valid);

endmodule

//--- verification/nmcp_tx_model.sv
/*
  Datagram transmitter model facing the parser's request port.
  Assumes start is a one-cycle pulse; busy follows it, done ends it.
*/
`timescale 1ns/1ps
module nmcp_tx_model #(
  parameter int MEAS_LEN = 4,
  parameter int SPEC_LEN = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Request and status
  input wire nmcp_pkg::nmcp_dg_req_s dg_req,
  output nmcp_pkg::nmcp_tx_stat_s tx_stat
);
  import nmcp_pkg::*;
  int count_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 0;
    end else if (dg_req.start) begin
      // Special datagrams outlast a measurement slot
      count_reg <= (dg_req.kind == NMCP_DG_MEASURE) ? MEAS_LEN : SPEC_LEN;
    end else if (count_reg > 0) begin
      count_reg <= count_reg - 1;
    end
  end
  assign tx_stat.busy = count_reg > 0;
  assign tx_stat.done = count_reg == 1;
endmodule

//--- verification/normal_mode_command_parser_bench.sv
/*
  Self-checking bench of the Normal Mode command parser.
  Assumes the transmitter model and the package; 40 MHz clock.
*/
`timescale 1ns/1ps
module normal_mode_command_parser_bench;
  import nmcp_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  nmcp_byte_s rx_byte = '0;
  logic aux_ready = 1'b0;
  logic meas_slot = 1'b0;
  logic ext_trig_mode = 1'b0;
  logic ext_trig_pin = 1'b0;
  logic incremental_mode = 1'b0;
  logic mode_exit = 1'b0;
  logic rx_ready, err_clear, unit_reset, listing_start, utility_ack_start, incr_discard;
  nmcp_byte_s aux_byte;
  nmcp_dg_req_s dg_req;
  nmcp_tx_stat_s tx_stat;
  nmcp_mode_e mode;
  int miscompares = 0;
  int check_count = 0;
  logic [3:0] exp_q[$];
  logic spec = 1'b0;
  logic [31:0] seed = 32'h5a97;
  logic [7:0] fill[16];
  int aux_idx;
  int aux_n;
  logic [7:0] ch[5] = '{CHAR_PART, CHAR_SERIAL, CHAR_CONFIG, CHAR_TRIM, CHAR_ERROR};
  nmcp_dg_kind_e kd[5] = '{NMCP_DG_PART, NMCP_DG_SERIAL, NMCP_DG_CONFIG, NMCP_DG_TRIM,
    NMCP_DG_ERROR};

  always #12.5 clock = ~clock;

  nmcp_parser dut (.clock(clock), .rst_n(rst_n), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .aux_byte(aux_byte), .aux_ready(aux_ready), .meas_slot(meas_slot),
    .ext_trig_mode(ext_trig_mode), .ext_trig_pin(ext_trig_pin),
    .incremental_mode(incremental_mode), .dg_req(dg_req), .tx_stat(tx_stat),
    .err_clear(err_clear), .unit_reset(unit_reset), .listing_start(listing_start),
    .utility_ack_start(utility_ack_start), .incr_discard(incr_discard),
    .mode_exit(mode_exit), .mode(mode));
  nmcp_tx_model #(.MEAS_LEN(4), .SPEC_LEN(40)) tx (.clock(clock), .rst_n(rst_n),
    .dg_req(dg_req), .tx_stat(tx_stat));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic pulse(input logic p, input logic [3:0] code);
    logic [3:0] e;
    if (p !== 1'b0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hf;
      check(p === 1'b1 && e === code, "unexpected output event");
    end
  endtask

  // Scoreboard of output events
  always @(posedge clock) begin
    if (rst_n) begin
      pulse(dg_req.start, {1'b0, dg_req.kind});
      pulse(err_clear, 4'h8);
      pulse(unit_reset, 4'h9);
      pulse(listing_start, 4'ha);
      pulse(utility_ack_start, 4'hb);
      check(incr_discard === (incremental_mode && ((tx_stat.busy && spec)
        || (dg_req.start && dg_req.kind != NMCP_DG_MEASURE))), "discard");
      if (dg_req.start) spec <= (dg_req.kind != NMCP_DG_MEASURE);
    end
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    rx_byte <= {1'b1, b};
    while (rx_ready !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
  endtask

  task automatic cmd(input string s);
    for (int i = 0; i < s.len(); i++) send(s[i]);
    send(CHAR_CR);
    rx_byte <= '0;
    idle(4);
  endtask

  task automatic word(input logic [WORD_CHARS*BYTE_W-1:0] w, input int n);
    for (int k = 0; k < n; k++) send(w[WORD_CHARS*BYTE_W-1-BYTE_W*k -: BYTE_W]);
    send(CHAR_CR);
    rx_byte <= '0;
    idle(4);
  endtask

  task automatic tick();
    meas_slot <= 1'b1;
    @(negedge clock);
    meas_slot <= 1'b0;
  endtask

  task automatic drain();
    int n;
    n = 0;
    @(negedge clock);
    while (tx_stat.busy && n < 100) begin
      @(negedge clock);
      n++;
    end
    idle(3);
  endtask

  task automatic leave();
    mode_exit <= 1'b1;
    @(negedge clock);
    mode_exit <= 1'b0;
    idle(2);
    check(mode === NMCP_MODE_NORMAL, "mode not normal");
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    test_done();
  end

  initial begin
    idle(10);
    rst_n <= 1'b1;
    idle(4);
    // Every request, alternate increment modes
    foreach (ch[i]) begin
      incremental_mode <= i[0];
      send(ch[i]);
      send(CHAR_CR);
      rx_byte <= '0;
      idle(4);
      exp_q.push_back({1'b0, kd[i]});
      if (i == 4) exp_q.push_back(4'h8);
      tick();
      drain();
    end
    // Bad input does nothing; a later letter replaces a pending one
    cmd("n");
    cmd("NN");
    word(SERVICE_WORD, WORD_CHARS - 1);
    cmd("Q");
    cmd("I");
    cmd("C");
    exp_q.push_back({1'b0, NMCP_DG_CONFIG});
    tick();
    idle(3);
    tick();
    drain();
    // External trigger
    ext_trig_mode <= 1'b1;
    cmd("T");
    exp_q.push_back({1'b0, NMCP_DG_TRIM});
    ext_trig_pin <= 1'b1;
    idle(6);
    ext_trig_pin <= 1'b0;
    drain();
    ext_trig_mode <= 1'b0;
    exp_q.push_back(4'h9);
    cmd("R");
    // Service word while a datagram is in flight
    cmd("N");
    exp_q.push_back({1'b0, NMCP_DG_PART});
    tick();
    exp_q.push_back(4'ha);
    word(SERVICE_WORD, WORD_CHARS);
    check(mode === NMCP_MODE_NORMAL, "switched early");
    drain();
    check(mode === NMCP_MODE_SERVICE, "no service mode");
    tick();
    foreach (fill[i]) begin
      seed = xs(seed);
      fill[i] = seed[7:0];
      send(fill[i]);
    end
    rx_byte <= '0;
    check(rx_ready === 1'b0, "fifo not full");
    aux_idx = 0;
    aux_n = 0;
    while (aux_idx < 16 && aux_n < 200) begin
      seed = xs(seed);
      check(aux_byte === {1'b1, fill[aux_idx]}, "aux byte");
      aux_ready <= seed[3];
      @(negedge clock);
      if (seed[3]) aux_idx++;
      aux_n++;
    end
    check(aux_idx == 16 && aux_byte.valid === 1'b0, "fifo not empty");
    aux_ready <= 1'b0;
    leave();
    exp_q.push_back(4'hb);
    word(UTILITY_WORD, WORD_CHARS);
    idle(2);
    check(mode === NMCP_MODE_UTILITY, "no utility mode");
    tick();
    idle(4);
    leave();
    check(exp_q.size() == 0, "missing output event");
    test_done();
  end
endmodule
